// ===== core/cfbs_cfg.svh
// Offsets, field positions, reset values and cycle counts of the execution slice.
// Assumes inclusion by bare name ahead of the package and the core.
`ifndef CFBS_CFG_SVH
`define CFBS_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CFBS_OFS_CMD      5'h00
`define CFBS_OFS_STATUS   5'h04
`define CFBS_OFS_PC       5'h08
`define CFBS_OFS_SEL      5'h0c
`define CFBS_OFS_REG      5'h10
`define CFBS_OFS_MEM      5'h14
`define CFBS_OFS_IO       5'h18

// ----------------------------------------
// Status flag positions
// ----------------------------------------
`define CFBS_FLAG_C       0
`define CFBS_FLAG_Z       1
`define CFBS_FLAG_N       2
`define CFBS_FLAG_V       3
`define CFBS_FLAG_S       4
`define CFBS_FLAG_H       5
`define CFBS_FLAG_T       6
`define CFBS_FLAG_I       7
`define CFBS_STAT_BUSY    8

// ----------------------------------------
// Reset values and cycle counts
// ----------------------------------------
`define CFBS_RST_FLAGS    8'h00
`define CFBS_RST_PC       16'h0000
`define CFBS_CYC_ONE      2'h1
`define CFBS_CYC_TWO      2'h2

`endif

// ===== core/cfbs_core.sv
// Execution slice of an 8-bit core: branches on T/V/I, shifts and rotates,
// bit moves, flag set/clear and indirect loads, driven over Avalon-MM.
// Assumes one 200 MHz clock and a master that holds each request until
// waitrequest is seen low.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "cfbs_cfg.svh"

module cfbs_core
    import cfbs_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [7:0]  status_flags_o,
    output logic      [15:0] pc_o,
    output logic             busy_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    cfbs_state_t state;
    cfbs_state_t next_state;
    cfbs_cmd_t   cmd;
    cfbs_cmd_t   next_cmd;
    logic [1:0]  cyc;
    logic [1:0]  next_cyc;
    logic [7:0]  sel;
    logic [7:0]  next_sel;
    logic [7:0]  regs      [16];
    logic [7:0]  next_regs [16];
    logic [7:0]  mem       [32];
    logic [7:0]  next_mem  [32];
    logic [7:0]  io        [32];
    logic [7:0]  next_io   [32];
    logic [7:0]  next_flags;
    logic [15:0] next_pc;
    logic [31:0] next_rdata;
    logic        next_wait;
    logic        next_busy;

    // ----------------------------------------
    // Scratch terms
    // ----------------------------------------
    logic        accept;
    logic        cond;
    logic        last;
    logic [7:0]  rd_val;
    logic [7:0]  res;
    logic [15:0] ptr;
    logic [3:0]  ptr_lo;
    logic [31:0] rd_mux;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Pointer pairs sit in the top six registers: X=11:10, Y=13:12, Z=15:14
    function automatic logic [3:0] ptr_index(input logic [1:0] p);
        unique case (p)
            2'h0:    ptr_index = 4'ha;
            2'h1:    ptr_index = 4'hc;
            default: ptr_index = 4'he;
        endcase
    endfunction

    // Data space is 32 bytes; anything above reads as zero
    function automatic logic [7:0] mem_read(input logic [7:0] m [32],
                                            input logic [15:0] a);
        if (a[15:5] == 11'h000) begin
            mem_read = m[a[4:0]];
        end else begin
            mem_read = 8'h00;
        end
    endfunction

    function automatic logic [7:0] set_zn(input logic [7:0] f,
                                          input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[`CFBS_FLAG_Z] = (r == 8'h00);
        o[`CFBS_FLAG_N] = r[7];
        set_zn = o;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_cmd   = cmd;
        next_cyc   = cyc;
        next_sel   = sel;
        next_regs  = regs;
        next_mem   = mem;
        next_io    = io;
        next_flags = status_flags_o;
        next_pc    = pc_o;
        next_rdata = avs_readdata_o;
        next_wait  = 1'b1;
        cond       = 1'b0;
        last       = 1'b1;
        res        = 8'h00;
        rd_val     = regs[cmd.dst];
        ptr_lo     = ptr_index(cmd.ptr);
        ptr        = {regs[ptr_lo + 4'h1], regs[ptr_lo]};

        // Bus: accesses stall while an operation runs so state is never torn
        accept = (avs_read_i | avs_write_i) & avs_waitrequest_o & (state == CFBS_IDLE);
        unique case (avs_address_i)
            `CFBS_OFS_CMD:    rd_mux = cmd;
            `CFBS_OFS_STATUS: rd_mux = {23'h000000, busy_o, status_flags_o};
            `CFBS_OFS_PC:     rd_mux = {16'h0000, pc_o};
            `CFBS_OFS_SEL:    rd_mux = {24'h000000, sel};
            `CFBS_OFS_REG:    rd_mux = {24'h000000, regs[sel[3:0]]};
            `CFBS_OFS_MEM:    rd_mux = {24'h000000, mem[sel[4:0]]};
            `CFBS_OFS_IO:     rd_mux = {24'h000000, io[sel[4:0]]};
            default:          rd_mux = 32'h00000000;
        endcase
        if (accept) begin
            next_wait = 1'b0;
            if (avs_read_i) begin
                next_rdata = rd_mux;
            end else begin
                unique case (avs_address_i)
                    `CFBS_OFS_CMD: begin
                        next_cmd   = cfbs_cmd_t'(avs_writedata_i);
                        next_state = CFBS_RUN;
                        next_cyc   = `CFBS_CYC_ONE;
                    end
                    `CFBS_OFS_STATUS: next_flags = avs_writedata_i[7:0];
                    `CFBS_OFS_PC:     next_pc = avs_writedata_i[15:0];
                    `CFBS_OFS_SEL:    next_sel = avs_writedata_i[7:0];
                    `CFBS_OFS_REG:    next_regs[sel[3:0]] = avs_writedata_i[7:0];
                    `CFBS_OFS_MEM:    next_mem[sel[4:0]] = avs_writedata_i[7:0];
                    `CFBS_OFS_IO:     next_io[sel[4:0]] = avs_writedata_i[7:0];
                    default: begin
                    end
                endcase
            end
        end

        // Execution
        if (state == CFBS_RUN) begin
            unique case (cmd.op)
                CFBS_BRANCH_TRANSFER_FLAG_CLEAR: cond = ~status_flags_o[`CFBS_FLAG_T];
                CFBS_BRANCH_TRANSFER_FLAG_SET:   cond = status_flags_o[`CFBS_FLAG_T];
                CFBS_BRANCH_OVERFLOW_SET:        cond = status_flags_o[`CFBS_FLAG_V];
                CFBS_BRANCH_OVERFLOW_CLEAR:      cond = ~status_flags_o[`CFBS_FLAG_V];
                CFBS_BRANCH_INT_ENABLED:         cond = status_flags_o[`CFBS_FLAG_I];
                CFBS_BRANCH_INT_DISABLED:        cond = ~status_flags_o[`CFBS_FLAG_I];
                CFBS_SHIFT_LEFT_LOGICAL: begin
                    res        = {rd_val[6:0], 1'b0};
                    next_flags = set_zn(status_flags_o, res);
                    next_flags[`CFBS_FLAG_C] = rd_val[7];
                    next_flags[`CFBS_FLAG_H] = rd_val[3];
                    next_flags[`CFBS_FLAG_V] = res[7] ^ rd_val[7];
                    next_regs[cmd.dst] = res;
                end
                CFBS_SHIFT_RIGHT_LOGICAL: begin
                    // Half-carry is left alone here on purpose
                    res        = {1'b0, rd_val[7:1]};
                    next_flags = set_zn(status_flags_o, res);
                    next_flags[`CFBS_FLAG_C] = rd_val[0];
                    next_flags[`CFBS_FLAG_V] = rd_val[0];
                    next_regs[cmd.dst] = res;
                end
                CFBS_ROTATE_LEFT_CARRY: begin
                    res        = {rd_val[6:0], status_flags_o[`CFBS_FLAG_C]};
                    next_flags = set_zn(status_flags_o, res);
                    next_flags[`CFBS_FLAG_C] = rd_val[7];
                    next_flags[`CFBS_FLAG_H] = rd_val[3];
                    next_flags[`CFBS_FLAG_V] = res[7] ^ rd_val[7];
                    next_regs[cmd.dst] = res;
                end
                CFBS_ROTATE_RIGHT_CARRY: begin
                    res        = {status_flags_o[`CFBS_FLAG_C], rd_val[7:1]};
                    next_flags = set_zn(status_flags_o, res);
                    next_flags[`CFBS_FLAG_C] = rd_val[0];
                    next_flags[`CFBS_FLAG_V] = res[7] ^ rd_val[0];
                    next_regs[cmd.dst] = res;
                end
                CFBS_IO_BIT_SET_OP: begin
                    next_io[cmd.k[4:0]][cmd.bsel] = 1'b1;
                end
                CFBS_IO_BIT_CLEAR_OP: begin
                    next_io[cmd.k[4:0]][cmd.bsel] = 1'b0;
                end
                CFBS_BIT_TO_TRANSFER_FLAG: begin
                    next_flags[`CFBS_FLAG_T] = regs[cmd.src][cmd.bsel];
                end
                CFBS_TRANSFER_FLAG_TO_BIT: begin
                    next_regs[cmd.dst][cmd.bsel] = status_flags_o[`CFBS_FLAG_T];
                end
                CFBS_FLAG_SET_OP: begin
                    next_flags[cmd.bsel] = 1'b1;
                end
                CFBS_GENERIC_FLAG_CLEAR: begin
                    next_flags[cmd.bsel] = 1'b0;
                end
                CFBS_INDIRECT_LOAD: begin
                    next_regs[cmd.dst] = mem_read(mem, ptr);
                end
                CFBS_INDIRECT_LOAD_POST_INC: begin
                    // Read in the first cycle, pointer step in the second
                    last = (cyc == `CFBS_CYC_TWO);
                    if (!last) begin
                        next_regs[cmd.dst] = mem_read(mem, ptr);
                    end else begin
                        {next_regs[ptr_lo + 4'h1], next_regs[ptr_lo]} = ptr + 16'h0001;
                    end
                end
                CFBS_INDIRECT_LOAD_PRE_DEC: begin
                    last = (cyc == `CFBS_CYC_TWO);
                    if (!last) begin
                        {next_regs[ptr_lo + 4'h1], next_regs[ptr_lo]} = ptr - 16'h0001;
                    end else begin
                        next_regs[cmd.dst] = mem_read(mem, ptr);
                    end
                end
                CFBS_IMMEDIATE_LOAD: begin
                    next_regs[cmd.dst] = cmd.k;
                end
                CFBS_REGISTER_COPY: begin
                    next_regs[cmd.dst] = regs[cmd.src];
                end
                default: begin
                end
            endcase

            // Condition is stable across both cycles since branches touch no flag
            if (cond) begin
                last = (cyc == `CFBS_CYC_TWO);
            end
            if (last) begin
                next_state = CFBS_IDLE;
                if (cond) begin
                    next_pc = pc_o + {{9{cmd.k[6]}}, cmd.k[6:0]} + 16'h0001;
                end else begin
                    next_pc = pc_o + 16'h0001;
                end
            end else begin
                next_cyc = cyc + `CFBS_CYC_ONE;
            end
        end
        next_busy = (next_state == CFBS_RUN);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state             <= CFBS_IDLE;
            cmd               <= '0;
            cyc               <= 2'h0;
            sel               <= 8'h00;
            status_flags_o    <= `CFBS_RST_FLAGS;
            pc_o              <= `CFBS_RST_PC;
            avs_readdata_o    <= 32'h00000000;
            avs_waitrequest_o <= 1'b1;
            busy_o            <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 8'h00;
            end
            for (int i = 0; i < 32; i++) begin
                mem[i] <= 8'h00;
                io[i]  <= 8'h00;
            end
        end else begin
            state             <= next_state;
            cmd               <= next_cmd;
            cyc               <= next_cyc;
            sel               <= next_sel;
            status_flags_o    <= next_flags;
            pc_o              <= next_pc;
            avs_readdata_o    <= next_rdata;
            avs_waitrequest_o <= next_wait;
            busy_o            <= next_busy;
            regs              <= next_regs;
            mem               <= next_mem;
            io                <= next_io;
        end
    end

endmodule

// ===== core/cfbs_pkg.sv
// Types shared by the execution slice: operations, command layout, states.
// Assumes cfbs_cfg.svh is compiled alongside.
package cfbs_pkg;

    typedef enum logic [4:0] {
        CFBS_NOP,
        CFBS_BRANCH_TRANSFER_FLAG_CLEAR,
        CFBS_BRANCH_TRANSFER_FLAG_SET,
        CFBS_BRANCH_OVERFLOW_SET,
        CFBS_BRANCH_OVERFLOW_CLEAR,
        CFBS_BRANCH_INT_ENABLED,
        CFBS_BRANCH_INT_DISABLED,
        CFBS_SHIFT_LEFT_LOGICAL,
        CFBS_SHIFT_RIGHT_LOGICAL,
        CFBS_ROTATE_LEFT_CARRY,
        CFBS_ROTATE_RIGHT_CARRY,
        CFBS_IO_BIT_SET_OP,
        CFBS_IO_BIT_CLEAR_OP,
        CFBS_BIT_TO_TRANSFER_FLAG,
        CFBS_TRANSFER_FLAG_TO_BIT,
        CFBS_FLAG_SET_OP,
        CFBS_GENERIC_FLAG_CLEAR,
        CFBS_INDIRECT_LOAD,
        CFBS_INDIRECT_LOAD_POST_INC,
        CFBS_INDIRECT_LOAD_PRE_DEC,
        CFBS_IMMEDIATE_LOAD,
        CFBS_REGISTER_COPY
    } cfbs_op_t;

    // Command word: k[31:24] ptr[21:20] bit[18:16] src[15:12] dst[11:8] op[4:0]
    typedef struct packed {
        logic [7:0] k;
        logic [1:0] rsv2;
        logic [1:0] ptr;
        logic       rsv1;
        logic [2:0] bsel;
        logic [3:0] src;
        logic [3:0] dst;
        logic [2:0] rsv0;
        cfbs_op_t   op;
    } cfbs_cmd_t;

    typedef enum logic {
        CFBS_IDLE,
        CFBS_RUN
    } cfbs_state_t;

endpackage

// ===== testbench/cfbs_core_assertions.sv
// Concurrent checks on the execution slice: handshake, busy span, branch and flag effects.
// Assumes binding to cfbs_core; sees only its ports.
`timescale 1ns/10ps
`include "cfbs_cfg.svh"

module cfbs_core_assertions
    import cfbs_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        resetn_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [7:0]  status_flags_o,
    input wire logic [15:0] pc_o,
    input wire logic        busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    logic        acc_cmd;
    cfbs_op_t    op;
    logic [2:0]  sel;
    logic [15:0] koff;
    // Command is accepted at the edge that samples waitrequest low
    assign acc_cmd = avs_write_i && !avs_waitrequest_o && (avs_address_i == `CFBS_OFS_CMD);
    assign op      = cfbs_op_t'(avs_writedata_i[4:0]);
    assign sel     = avs_writedata_i[18:16];
    assign koff    = {{9{avs_writedata_i[30]}}, avs_writedata_i[30:24]} + 16'h0001;

    a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_wait_needs_req: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
        else $error("waitrequest dropped without a request");
    a_cmd_sets_busy: assert property (acc_cmd |-> busy_o)
        else $error("busy not raised for a command");
    a_busy_bounded: assert property (busy_o |-> ##[1:2] !busy_o)
        else $error("operation ran longer than two cycles");
    a_branch_untaken: assert property ((acc_cmd
        && ((op == CFBS_BRANCH_INT_ENABLED && !status_flags_o[7])
        || (op == CFBS_BRANCH_TRANSFER_FLAG_CLEAR && status_flags_o[6])))
        |=> (pc_o == $past(pc_o) + 16'h0001) && !busy_o)
        else $error("untaken branch wrong pc or length");
    a_branch_taken: assert property ((acc_cmd
        && op == CFBS_BRANCH_OVERFLOW_SET && status_flags_o[3])
        |=> busy_o ##1 (pc_o == $past(pc_o, 2) + $past(koff, 2)) && !busy_o)
        else $error("taken branch wrong pc or length");
    a_flag_set_one: assert property ((acc_cmd && op == CFBS_FLAG_SET_OP)
        |=> status_flags_o == ($past(status_flags_o) | (8'h01 << $past(sel))))
        else $error("flag set touched wrong bits");
    a_flag_clear_one: assert property ((acc_cmd && op == CFBS_GENERIC_FLAG_CLEAR)
        |=> status_flags_o == ($past(status_flags_o) & ~(8'h01 << $past(sel))))
        else $error("flag clear touched wrong bits");
    a_bit_store_t: assert property ((acc_cmd && op == CFBS_BIT_TO_TRANSFER_FLAG)
        |=> (status_flags_o & 8'hbf) == ($past(status_flags_o) & 8'hbf))
        else $error("bit store changed a flag other than transfer");
    a_flags_kept: assert property ((acc_cmd
        && (op == CFBS_IO_BIT_SET_OP || op == CFBS_IO_BIT_CLEAR_OP
        || op == CFBS_TRANSFER_FLAG_TO_BIT)) |=> $stable(status_flags_o))
        else $error("flags changed by a flag-neutral operation");
    a_unmapped_zero: assert property ((avs_read_i && !avs_waitrequest_o && avs_address_i > `CFBS_OFS_IO)
        |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind cfbs_core cfbs_core_assertions cfbs_core_assertions_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .status_flags_o(status_flags_o), .pc_o(pc_o), .busy_o(busy_o));

// ===== testbench/testbench.sv
// Self-checking bench for the execution slice, driving commands over Avalon-MM.
// Assumes the core answers every request after some wait states.
`timescale 1ns/10ps
`include "cfbs_cfg.svh"

module testbench
    import cfbs_pkg::*;
;
    logic        clock_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o, busy_o;
    logic [4:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [7:0]  status_flags_o;
    logic [15:0] pc_o, ex;
    int          miscompares, n_compared, cycles;

    cfbs_core cfbs_core_i (.clock_i(clock_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .status_flags_o(status_flags_o), .pc_o(pc_o), .busy_o(busy_o));

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // ----------------------------------------
    // Bus access and comparison
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request stands until a rising edge samples waitrequest low; read data is taken at that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        avs_address_i   <= a;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        avs_writedata_i <= d;
        @(posedge clock_i);
        while (avs_waitrequest_o) begin
            @(posedge clock_i);
        end
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
        bus(1'b0, a, 32'h0, q);
        check(q & m, exp & m);
    endtask

    task automatic setr(input int i, input logic [7:0] v);
        wr(`CFBS_OFS_SEL, 32'(i));
        wr(`CFBS_OFS_REG, {24'h0, v});
    endtask

    task automatic getr(input int i, input logic [7:0] v);
        wr(`CFBS_OFS_SEL, 32'(i));
        rd(`CFBS_OFS_REG, {24'h0, v});
    endtask

    task automatic run(input int op, input int dst, input int src, input int b, input int p, input logic [7:0] k);
        cfbs_cmd_t c;
        c      = '0;
        c.op   = cfbs_op_t'(op[4:0]);
        c.dst  = dst[3:0];
        c.src  = src[3:0];
        c.bsel = b[2:0];
        c.ptr  = p[1:0];
        c.k    = k;
        wr(`CFBS_OFS_CMD, c);
    endtask

    // Expected {flags, result} of the four shifts; S is never touched
    function automatic logic [15:0] shift_exp(input int op, input logic [7:0] v, input logic [7:0] f);
        logic [7:0] r;
        logic [7:0] g;
        g = f;
        case (op)
            7: r = {v[6:0], 1'b0};
            8: r = {1'b0, v[7:1]};
            9: r = {v[6:0], f[`CFBS_FLAG_C]};
            default: r = {f[`CFBS_FLAG_C], v[7:1]};
        endcase
        g[`CFBS_FLAG_C] = (op == 7 || op == 9) ? v[7] : v[0];
        if (op == 7 || op == 9) g[`CFBS_FLAG_H] = v[3];
        g[`CFBS_FLAG_N] = r[7];
        g[`CFBS_FLAG_Z] = (r == 8'h00);
        g[`CFBS_FLAG_V] = g[`CFBS_FLAG_N] ^ g[`CFBS_FLAG_C];
        return {g, r};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int         bp[6]  = '{6, 6, 3, 3, 7, 7};
        int         pol[6] = '{0, 1, 1, 0, 1, 0};
        logic [7:0] fl;
        resetn_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 5'h00;
        avs_writedata_i = 32'h0;
        repeat (4) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        rd(5'h1c, 32'h0);
        for (int i = 1; i <= 6; i++) begin
            for (int f = 0; f < 2; f++) begin
                fl = f ? (8'h01 << bp[i-1]) : ~(8'h01 << bp[i-1]);
                wr(`CFBS_OFS_STATUS, {24'h0, fl});
                wr(`CFBS_OFS_PC, 32'h0040);
                run(i, 0, 0, 0, 0, f ? 8'h7e : 8'h05);
                ex = (f == pol[i-1]) ? (f ? 16'h003f : 16'h0046) : 16'h0041;
                rd(`CFBS_OFS_PC, {16'h0, ex});
                check({16'h0, pc_o}, {16'h0, ex});
                rd(`CFBS_OFS_STATUS, {24'h0, fl});
                check({24'h0, status_flags_o}, {24'h0, fl});
            end
        end
        for (int op = 7; op <= 10; op++) begin
            for (int j = 0; j < 2; j++) begin
                fl = j ? 8'h20 : 8'h21;
                setr(4, j ? 8'h01 : 8'h88);
                wr(`CFBS_OFS_STATUS, {24'h0, fl});
                run(op, 4, 4, 0, 0, 8'h00);
                ex = shift_exp(op, j ? 8'h01 : 8'h88, fl);
                getr(4, ex[7:0]);
                rd(`CFBS_OFS_STATUS, {24'h0, ex[15:8]});
            end
        end
        wr(`CFBS_OFS_SEL, 32'h3);
        wr(`CFBS_OFS_IO, 32'h5a);
        wr(`CFBS_OFS_STATUS, 32'h55);
        run(CFBS_IO_BIT_SET_OP, 0, 0, 0, 0, 8'h03);
        run(CFBS_IO_BIT_CLEAR_OP, 0, 0, 6, 0, 8'h03);
        wr(`CFBS_OFS_SEL, 32'h3);
        rd(`CFBS_OFS_IO, 32'h1b);
        rd(`CFBS_OFS_STATUS, 32'h55);
        setr(2, 8'h10);
        setr(5, 8'h80);
        wr(`CFBS_OFS_STATUS, 32'h0);
        run(CFBS_BIT_TO_TRANSFER_FLAG, 2, 2, 4, 0, 8'h00);
        rd(`CFBS_OFS_STATUS, 32'h40);
        run(CFBS_TRANSFER_FLAG_TO_BIT, 5, 5, 0, 0, 8'h00);
        getr(5, 8'h81);
        wr(`CFBS_OFS_STATUS, 32'hbf);
        run(CFBS_BIT_TO_TRANSFER_FLAG, 2, 2, 0, 0, 8'h00);
        rd(`CFBS_OFS_STATUS, 32'hbf);
        run(CFBS_TRANSFER_FLAG_TO_BIT, 5, 5, 7, 0, 8'h00);
        getr(5, 8'h01);
        wr(`CFBS_OFS_STATUS, 32'h0);
        for (int s = 0; s < 8; s++) begin
            run(CFBS_FLAG_SET_OP, 0, 0, s, 0, 8'h00);
            rd(`CFBS_OFS_STATUS, (32'h2 << s) - 32'h1);
        end
        for (int s = 0; s < 8; s++) begin
            run(CFBS_GENERIC_FLAG_CLEAR, 0, 0, s, 0, 8'h00);
            rd(`CFBS_OFS_STATUS, 32'hff & (32'hff << (s + 1)));
        end
        wr(`CFBS_OFS_SEL, 32'h5);
        wr(`CFBS_OFS_MEM, 32'ha5);
        for (int p = 0; p < 3; p++) begin
            setr(10 + 2 * p, 8'h05);
            setr(11 + 2 * p, 8'h00);
            setr(1, 8'h00);
            run(CFBS_INDIRECT_LOAD, 1, 1, 0, p, 8'h00);
            getr(1, 8'ha5);
            getr(10 + 2 * p, 8'h05);
        end
        run(CFBS_INDIRECT_LOAD_POST_INC, 2, 2, 0, 1, 8'h00);
        getr(2, 8'ha5);
        getr(12, 8'h06);
        run(CFBS_INDIRECT_LOAD_PRE_DEC, 3, 3, 0, 1, 8'h00);
        getr(3, 8'ha5);
        getr(12, 8'h05);
        run(CFBS_IMMEDIATE_LOAD, 7, 7, 0, 0, 8'hc3);
        run(CFBS_REGISTER_COPY, 8, 7, 0, 0, 8'h00);
        getr(8, 8'hc3);
        tally_and_finish();
    end
endmodule
